// ### design/spd_pkg.sv
package spd_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [5:0] IDX_P1_OUT_LOOP = 6'h07;
    localparam logic [5:0] IDX_P1_EXT_FSK = 6'h08;
    localparam logic [5:0] IDX_P1_DEV_FIRST = 6'h09;
    localparam logic [5:0] IDX_P1_DEV_LAST = 6'h10;
    localparam logic [5:0] IDX_P2_FRAC_HIGH = 6'h11;
    localparam logic [5:0] IDX_P2_NUM_LOW = 6'h12;
    localparam logic [5:0] IDX_P2_DEN_LOW = 6'h13;
    localparam logic [5:0] IDX_P2_INT_DIV = 6'h14;
    localparam logic [5:0] IDX_P2_REF_DIV = 6'h15;
    localparam int DEV_COUNT = 8;

    // Reset values.
    localparam logic [15:0] RST_P1_OUT_LOOP = 16'h10A4;
    localparam logic [15:0] RST_P1_EXT_FSK = 16'h0010;
    localparam logic [15:0] RST_P1_DEV = 16'h0000;
    localparam logic [15:0] RST_P2_FRAC_HIGH = 16'h0000;
    localparam logic [15:0] RST_P2_NUM_LOW = 16'h0000;
    localparam logic [15:0] RST_P2_DEN_LOW = 16'h0000;
    localparam logic [15:0] RST_P2_INT_DIV = 16'h0028;
    localparam logic [15:0] RST_P2_REF_DIV = 16'h0101;

    // Field positions.
    localparam int POS_PRESCALER = 15;
    localparam int POS_ORDER_LO = 12;
    localparam int POS_FSK_EN = 10;
    localparam int POS_EXTDIV_LO = 6;
    localparam int POS_EXT_SEL = 5;
    localparam int POS_POST_LO = 8;
    localparam logic [11:0] FEEDBACK_MAX = 12'h03FF;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded second-profile divider settings.
    typedef struct packed {
        logic [7:0] ref_post_divider_p2;
        logic [7:0] ref_pre_divider_p2;
        logic [2:0] prescaler_ratio_p2;
        logic [2:0] modulator_order_p2;
        logic integer_mode_p2;
        logic [11:0] feedback_integer_p2;
        logic feedback_over_max_p2;
        logic [23:0] frac_numerator_p2;
        logic [23:0] frac_denominator_p2;
    } spd_p2_cfg_t;

    // Decoded first-profile external oscillator and level settings.
    typedef struct packed {
        logic shift_keying_enable_p1;
        logic [3:0] ext_osc_out_divider_p1;
        logic ext_div_reserved_p1;
        logic ext_osc_select_p1;
        logic [4:0] tx_output_level_p1;
        logic reserved_bits_set_p1;
    } spd_p1_cfg_t;

endpackage : spd_pkg

// ### design/spd_ext_div_dec.sv
`timescale 1ns/1ps
// Decodes the external-path output divider code into a ratio.
module spd_ext_div_dec (
    // Code in.
    input wire logic [3:0] i_code,
    // Decoded ratio out.
    output logic [3:0] o_ratio,
    output logic o_reserved
);

    // Code 0 is divide by one, 2 to 10 divide by their value; others reserved.
    always_comb
    begin
        o_ratio = 4'h1;
        o_reserved = 1'b0;
        if (i_code == 4'h1 || i_code > 4'hA)
        begin
            o_reserved = 1'b1;
        end
        else if (i_code != 4'h0)
        begin
            o_ratio = i_code;
        end
    end

endmodule : spd_ext_div_dec

// ### design/spd_regs.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - Post-divider for profile two sits in bits 15-8, reset value one.
// - Prescaler bit 15: clear divides by 2, set divides by 4.
// - Order field 0 integer, 1-3 that order, 4-7 fourth order.
// - Feedback integer is 12 bits, resets 28h, software keeps it <= 1023.
// - Denominator = high byte of shared word, then its low word.
// - Numerator = low byte of shared word, then its low word.
// - Eight sixteen-bit deviation words, read-write, reset zero.
// - Shift-keying enable bit 10, divider 9-6, select 5, level 4-0.
// - Select clear means internal oscillator, set means external loop only.
// - Divider code 0 is one, 2-10 that value, 1 and 11-15 reserved.
module spd_regs #(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // AXI4-Lite write response.
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read address and data.
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Decoded and raw settings for the synthesizer core.
    output spd_pkg::spd_p2_cfg_t o_p2_cfg,
    output spd_pkg::spd_p1_cfg_t o_p1_cfg,
    output logic [15:0] o_p1_output_loop_cfg,
    output logic [16*spd_pkg::DEV_COUNT-1:0] o_deviation_words_p1
);

    // Register storage.
    logic [15:0] p1_out_loop_reg;
    logic [15:0] p1_ext_fsk_reg;
    logic [15:0] dev_reg [spd_pkg::DEV_COUNT];
    logic [15:0] p2_frac_high_reg;
    logic [15:0] p2_num_low_reg;
    logic [15:0] p2_den_low_reg;
    logic [15:0] p2_int_div_reg;
    logic [15:0] p2_ref_div_reg;

    // Write channel capture.
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic write_fire;
    logic [5:0] w_idx;
    logic [5:0] r_idx;

    // Index from a byte address; unaligned low bits are dropped.
    function automatic logic [5:0] addr_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] shifted;
        shifted = a >> 2;
        addr_index = shifted[5:0];
    endfunction : addr_index

    // Address mapped when its index names a register and upper bits are 0.
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic [5:0] idx;
        logic [ADDR_W-1:0] top;
        idx = addr_index(a);
        top = a >> 8;
        addr_mapped = (top == '0) && idx >= spd_pkg::IDX_P1_OUT_LOOP
            && idx <= spd_pkg::IDX_P2_REF_DIV;
    endfunction : addr_mapped

    // Merge the two low byte lanes of a write into a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] d, input logic [3:0] s);
        merge16 = old;
        if (s[0])
        begin
            merge16[7:0] = d[7:0];
        end
        if (s[1])
        begin
            merge16[15:8] = d[15:8];
        end
    endfunction : merge16

    // Address and data are taken in either order, one write at a time.
    assign o_awready = !aw_held_reg && !o_bvalid;
    assign o_wready = !w_held_reg && !o_bvalid;
    assign write_fire = aw_held_reg && w_held_reg && !o_bvalid;
    assign w_idx = addr_index(awaddr_reg);

    // Capture of write address.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end
        else if (i_awvalid && o_awready)
        begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= i_awaddr;
        end
        else if (write_fire)
        begin
            aw_held_reg <= 1'b0;
        end
    end

    // Capture of write data.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end
        else if (i_wvalid && o_wready)
        begin
            w_held_reg <= 1'b1;
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
        end
        else if (write_fire)
        begin
            w_held_reg <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR and store nothing.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_bvalid <= 1'b0;
            o_bresp <= spd_pkg::RESP_OKAY;
        end
        else if (write_fire)
        begin
            o_bvalid <= 1'b1;
            o_bresp <= addr_mapped(awaddr_reg) ? spd_pkg::RESP_OKAY
                : spd_pkg::RESP_SLVERR;
        end
        else if (i_bready)
        begin
            o_bvalid <= 1'b0;
        end
    end

    // Single registers; each holds its value until written or reset.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            p1_out_loop_reg <= spd_pkg::RST_P1_OUT_LOOP;
            p1_ext_fsk_reg <= spd_pkg::RST_P1_EXT_FSK;
            p2_frac_high_reg <= spd_pkg::RST_P2_FRAC_HIGH;
            p2_num_low_reg <= spd_pkg::RST_P2_NUM_LOW;
            p2_den_low_reg <= spd_pkg::RST_P2_DEN_LOW;
            p2_int_div_reg <= spd_pkg::RST_P2_INT_DIV;
            p2_ref_div_reg <= spd_pkg::RST_P2_REF_DIV;
        end
        else if (write_fire && addr_mapped(awaddr_reg))
        begin
            case (w_idx)
                spd_pkg::IDX_P1_OUT_LOOP:
                    p1_out_loop_reg <= merge16(p1_out_loop_reg, wdata_reg,
                        wstrb_reg);
                spd_pkg::IDX_P1_EXT_FSK:
                    p1_ext_fsk_reg <= merge16(p1_ext_fsk_reg, wdata_reg,
                        wstrb_reg);
                spd_pkg::IDX_P2_FRAC_HIGH:
                    p2_frac_high_reg <= merge16(p2_frac_high_reg, wdata_reg,
                        wstrb_reg);
                spd_pkg::IDX_P2_NUM_LOW:
                    p2_num_low_reg <= merge16(p2_num_low_reg, wdata_reg,
                        wstrb_reg);
                spd_pkg::IDX_P2_DEN_LOW:
                    p2_den_low_reg <= merge16(p2_den_low_reg, wdata_reg,
                        wstrb_reg);
                spd_pkg::IDX_P2_INT_DIV:
                    p2_int_div_reg <= merge16(p2_int_div_reg, wdata_reg,
                        wstrb_reg);
                spd_pkg::IDX_P2_REF_DIV:
                    p2_ref_div_reg <= merge16(p2_ref_div_reg, wdata_reg,
                        wstrb_reg);
                default:
                    p1_out_loop_reg <= p1_out_loop_reg;
            endcase
        end
    end

    // Deviation words sit at consecutive indices.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < spd_pkg::DEV_COUNT; i++)
            begin
                dev_reg[i] <= spd_pkg::RST_P1_DEV;
            end
        end
        else if (write_fire && w_idx >= spd_pkg::IDX_P1_DEV_FIRST
            && w_idx <= spd_pkg::IDX_P1_DEV_LAST && addr_mapped(awaddr_reg))
        begin
            dev_reg[3'(w_idx - spd_pkg::IDX_P1_DEV_FIRST)] <=
                merge16(dev_reg[3'(w_idx - spd_pkg::IDX_P1_DEV_FIRST)],
                wdata_reg, wstrb_reg);
        end
    end

    // Read path: one read at a time, data registered with rvalid.
    assign o_arready = !o_rvalid;
    assign r_idx = addr_index(i_araddr);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= spd_pkg::RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_rvalid <= 1'b1;
            o_rresp <= addr_mapped(i_araddr) ? spd_pkg::RESP_OKAY
                : spd_pkg::RESP_SLVERR;
            o_rdata <= '0;
            if (addr_mapped(i_araddr))
            begin
                case (r_idx)
                    spd_pkg::IDX_P1_OUT_LOOP:
                        o_rdata <= {16'h0000, p1_out_loop_reg};
                    spd_pkg::IDX_P1_EXT_FSK:
                        o_rdata <= {16'h0000, p1_ext_fsk_reg};
                    spd_pkg::IDX_P2_FRAC_HIGH:
                        o_rdata <= {16'h0000, p2_frac_high_reg};
                    spd_pkg::IDX_P2_NUM_LOW:
                        o_rdata <= {16'h0000, p2_num_low_reg};
                    spd_pkg::IDX_P2_DEN_LOW:
                        o_rdata <= {16'h0000, p2_den_low_reg};
                    spd_pkg::IDX_P2_INT_DIV:
                        o_rdata <= {16'h0000, p2_int_div_reg};
                    spd_pkg::IDX_P2_REF_DIV:
                        o_rdata <= {16'h0000, p2_ref_div_reg};
                    default:
                        o_rdata <= {16'h0000,
                            dev_reg[3'(r_idx - spd_pkg::IDX_P1_DEV_FIRST)]};
                endcase
            end
        end
        else if (i_rready)
        begin
            o_rvalid <= 1'b0;
        end
    end

    // External divider decode; its ratio and reserved flag feed only the profile-one word.
    logic [3:0] ext_ratio;
    logic ext_reserved;
    spd_ext_div_dec u_ext_div (
        .i_code(p1_ext_fsk_reg[spd_pkg::POS_EXTDIV_LO +: 4]),
        .o_ratio(ext_ratio),
        .o_reserved(ext_reserved)
    );

    // Profile-two decode; order codes above three all mean fourth order.
    always_comb
    begin
        o_p2_cfg.ref_post_divider_p2 =
            p2_ref_div_reg[spd_pkg::POS_POST_LO +: 8];
        o_p2_cfg.ref_pre_divider_p2 = p2_ref_div_reg[7:0];
        o_p2_cfg.prescaler_ratio_p2 =
            p2_int_div_reg[spd_pkg::POS_PRESCALER] ? 3'h4 : 3'h2;
        o_p2_cfg.modulator_order_p2 =
            p2_int_div_reg[spd_pkg::POS_ORDER_LO + 2] ? 3'h4
            : p2_int_div_reg[spd_pkg::POS_ORDER_LO +: 3];
        o_p2_cfg.integer_mode_p2 =
            p2_int_div_reg[spd_pkg::POS_ORDER_LO +: 3] == 3'h0;
        o_p2_cfg.feedback_integer_p2 = p2_int_div_reg[11:0];
        o_p2_cfg.feedback_over_max_p2 =
            p2_int_div_reg[11:0] > spd_pkg::FEEDBACK_MAX;
        o_p2_cfg.frac_numerator_p2 =
            {p2_frac_high_reg[7:0], p2_num_low_reg};
        o_p2_cfg.frac_denominator_p2 =
            {p2_frac_high_reg[15:8], p2_den_low_reg};
    end

    // Profile-one oscillator word; select clear keeps the internal one.
    always_comb
    begin
        o_p1_cfg.shift_keying_enable_p1 =
            p1_ext_fsk_reg[spd_pkg::POS_FSK_EN];
        o_p1_cfg.ext_osc_out_divider_p1 = ext_ratio;
        o_p1_cfg.ext_div_reserved_p1 = ext_reserved;
        o_p1_cfg.ext_osc_select_p1 =
            p1_ext_fsk_reg[spd_pkg::POS_EXT_SEL];
        o_p1_cfg.tx_output_level_p1 = p1_ext_fsk_reg[4:0];
        o_p1_cfg.reserved_bits_set_p1 = p1_ext_fsk_reg[15:11] != 5'h00;
    end

    assign o_p1_output_loop_cfg = p1_out_loop_reg;

    // Flatten deviation words, word 0 lowest.
    always_comb
    begin
        for (int i = 0; i < spd_pkg::DEV_COUNT; i++)
        begin
            o_deviation_words_p1[16*i +: 16] = dev_reg[i];
        end
    end

    // A completed write is answered on the next edge.
    a_write_answers: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        write_fire |=> o_bvalid)
        else $error("write not answered");

    // Read of a reserved-zero upper half stays zero.
    a_read_upper_zero: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) o_rvalid |-> o_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    a_prescaler_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_p2_cfg.prescaler_ratio_p2 ==
        (p2_int_div_reg[15] ? 3'h4 : 3'h2))
        else $error("prescaler ratio wrong");

    a_order_cap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_p2_cfg.modulator_order_p2 <= 3'h4)
        else $error("order above four");

    a_num_assemble: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_p2_cfg.frac_numerator_p2[23:16] == p2_frac_high_reg[7:0])
        else $error("numerator high wrong");

    a_den_assemble: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_p2_cfg.frac_denominator_p2[15:0] == p2_den_low_reg)
        else $error("denominator low wrong");

    a_post_div_field: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        $rose(i_rst_n) |-> o_p2_cfg.ref_post_divider_p2 == 8'h01)
        else $error("post divider reset wrong");

    a_regs_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !write_fire |=> $stable(p2_int_div_reg))
        else $error("register changed without write");

    a_ext_sel_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_p1_cfg.ext_osc_select_p1 == p1_ext_fsk_reg[5])
        else $error("select bit wrong");

endmodule : spd_regs

// ### dv/spd_regs_test.sv
`timescale 1ns/1ps
// Self-checking bench for the profile divider register bank.
module spd_regs_test;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_awaddr = 8'h00;
    logic i_awvalid = 1'b0;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0] i_wstrb = 4'h0;
    logic i_wvalid = 1'b0;
    logic i_bready = 1'b1;
    logic [7:0] i_araddr = 8'h00;
    logic i_arvalid = 1'b0;
    logic i_rready = 1'b1;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    spd_pkg::spd_p2_cfg_t o_p2_cfg;
    spd_pkg::spd_p1_cfg_t o_p1_cfg;
    logic [15:0] o_p1_output_loop_cfg;
    logic [16*spd_pkg::DEV_COUNT-1:0] o_deviation_words_p1;
    int n_fail = 0;
    int n_tests = 0;

    // The response ready lines stay high; the bench never stalls answers.
    spd_regs #(.ADDR_W(8)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_p2_cfg(o_p2_cfg),
        .o_p1_cfg(o_p1_cfg), .o_p1_output_loop_cfg(o_p1_output_loop_cfg),
        .o_deviation_words_p1(o_deviation_words_p1));

    // Clock at 200 MHz.
    always #2.5 i_clk = ~i_clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Checks made: %0d, mismatches: %0d.", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // Compares one value; four-state equality so unknowns never match.
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Byte address of a register index.
    function automatic logic [7:0] ad(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction : ad

    // Ready is sampled at the falling edge, where it equals its value at
    // the next rising edge, so a release never races the design.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] r);
        int n;
        logic aw_t, w_t, b_t;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        n = 0;
        b_t = 1'b0;
        r = 2'h3;
        while (!b_t && n < 40)
        begin
            @(negedge i_clk);
            aw_t = i_awvalid && o_awready;
            w_t = i_wvalid && o_wready;
            b_t = o_bvalid;
            r = o_bresp;
            @(posedge i_clk);
            if (aw_t) i_awvalid <= 1'b0;
            if (w_t) i_wvalid <= 1'b0;
            n++;
        end
        if (!b_t) chk("write answer", 32'h0, 32'h1);
    endtask : wr

    // One read; waits for rvalid under a bounded count.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        logic ar_t, r_t;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        n = 0;
        r_t = 1'b0;
        while (!r_t && n < 40)
        begin
            @(negedge i_clk);
            ar_t = i_arvalid && o_arready;
            r_t = o_rvalid;
            d = o_rdata;
            r = o_rresp;
            @(posedge i_clk);
            if (ar_t) i_arvalid <= 1'b0;
            n++;
        end
        if (!r_t) chk("read answer", 32'h0, 32'h1);
    endtask : rd

    // Writes a 16-bit word with both lanes and expects an OKAY answer.
    task automatic wr16(input logic [5:0] idx, input logic [15:0] v);
        logic [1:0] r;
        wr(ad(idx), {16'h0000, v}, 4'h3, r);
        chk("bresp", r, spd_pkg::RESP_OKAY);
    endtask : wr16

    // Reads a word back and compares it and its response.
    task automatic rchk(input logic [5:0] idx, input logic [15:0] v);
        logic [31:0] d;
        logic [1:0] r;
        rd(ad(idx), d, r);
        chk("rdata", d, {16'h0000, v});
        chk("rresp", r, spd_pkg::RESP_OKAY);
    endtask : rchk

    // Reset value of every mapped index.
    function automatic logic [15:0] rst_of(input logic [5:0] i);
        if (i == spd_pkg::IDX_P1_OUT_LOOP) return spd_pkg::RST_P1_OUT_LOOP;
        if (i == spd_pkg::IDX_P1_EXT_FSK) return spd_pkg::RST_P1_EXT_FSK;
        if (i <= spd_pkg::IDX_P1_DEV_LAST) return spd_pkg::RST_P1_DEV;
        if (i == spd_pkg::IDX_P2_INT_DIV) return spd_pkg::RST_P2_INT_DIV;
        if (i == spd_pkg::IDX_P2_REF_DIV) return spd_pkg::RST_P2_REF_DIV;
        return 16'h0000;
    endfunction : rst_of

    // Every register reads its default; decoded defaults agree.
    task automatic t_reset();
        for (int i = 7; i <= 21; i++)
            rchk(6'(i), rst_of(6'(i)));
        chk("post div", o_p2_cfg.ref_post_divider_p2, 32'h1);
        chk("feedback", o_p2_cfg.feedback_integer_p2, 32'h28);
        chk("level", o_p1_cfg.tx_output_level_p1, 32'h10);
        chk("loop cfg", o_p1_output_loop_cfg, spd_pkg::RST_P1_OUT_LOOP);
    endtask : t_reset

    // Pre-divider kept below the default multiplier of four by software.
    task automatic t_ref_div();
        wr16(spd_pkg::IDX_P2_REF_DIV, 16'hAB03);
        chk("post div", o_p2_cfg.ref_post_divider_p2, 32'hAB);
        chk("pre div", o_p2_cfg.ref_pre_divider_p2, 32'h03);
        rchk(spd_pkg::IDX_P2_REF_DIV, 16'hAB03);
    endtask : t_ref_div

    // Every order code with both prescaler settings and the count limit.
    task automatic t_int_div();
        logic [11:0] n;
        for (int o = 0; o < 8; o++)
        begin
            n = o[0] ? 12'h400 : 12'h3FF;
            wr16(spd_pkg::IDX_P2_INT_DIV, {o[0], 3'(o), n});
            chk("ratio", o_p2_cfg.prescaler_ratio_p2, o[0] ? 4 : 2);
            chk("order", o_p2_cfg.modulator_order_p2, o > 3 ? 4 : o);
            chk("int mode", o_p2_cfg.integer_mode_p2, o == 0);
            chk("feedback", o_p2_cfg.feedback_integer_p2, n);
            chk("over max", o_p2_cfg.feedback_over_max_p2, o[0]);
        end
    endtask : t_int_div

    // Numerator and denominator assembly from three registers.
    task automatic t_frac();
        wr16(spd_pkg::IDX_P2_FRAC_HIGH, 16'hA5C3);
        wr16(spd_pkg::IDX_P2_NUM_LOW, 16'h1234);
        wr16(spd_pkg::IDX_P2_DEN_LOW, 16'h5678);
        chk("num", o_p2_cfg.frac_numerator_p2, 32'h00C3_1234);
        chk("den", o_p2_cfg.frac_denominator_p2, 32'h00A5_5678);
    endtask : t_frac

    // Deviation words, then a reset in mid-run brings them back to zero.
    task automatic t_dev();
        for (int k = 0; k < 8; k++)
            wr16(6'(9 + k), 16'(16'h1111 * (k + 1)));
        for (int k = 0; k < 8; k++)
        begin
            rchk(6'(9 + k), 16'(16'h1111 * (k + 1)));
            chk("dev out", o_deviation_words_p1[16*k +: 16],
                16'h1111 * (k + 1));
        end
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        chk("dev rst", o_deviation_words_p1[15:0], 32'h0);
        rchk(6'h10, spd_pkg::RST_P1_DEV);
    endtask : t_dev

    // All sixteen divider codes with the other fields of the word.
    task automatic t_ext();
        logic [3:0] c;
        for (int i = 0; i < 16; i++)
        begin
            c = 4'(i);
            wr16(spd_pkg::IDX_P1_EXT_FSK,
                {5'h00, c[0], c, c[1], 5'(i + 1)});
            chk("fsk", o_p1_cfg.shift_keying_enable_p1, c[0]);
            chk("select", o_p1_cfg.ext_osc_select_p1, c[1]);
            chk("level", o_p1_cfg.tx_output_level_p1, i + 1);
            chk("ratio", o_p1_cfg.ext_osc_out_divider_p1,
                (i >= 2 && i <= 10) ? i : 1);
            chk("resv", o_p1_cfg.ext_div_reserved_p1,
                i == 1 || i > 10);
            chk("bits set", o_p1_cfg.reserved_bits_set_p1, 32'h0);
        end
        wr16(spd_pkg::IDX_P1_EXT_FSK, 16'hF800);
        chk("bits set", o_p1_cfg.reserved_bits_set_p1, 32'h1);
    endtask : t_ext

    // Unmapped places answer with an error; byte lanes write alone.
    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        wr(ad(6'h06), 32'h0000_FFFF, 4'h3, r);
        chk("bresp err", r, spd_pkg::RESP_SLVERR);
        rd(ad(6'h16), d, r);
        chk("rresp err", r, spd_pkg::RESP_SLVERR);
        chk("rdata err", d, 32'h0);
        rchk(spd_pkg::IDX_P1_OUT_LOOP, spd_pkg::RST_P1_OUT_LOOP);
        wr16(spd_pkg::IDX_P1_OUT_LOOP, 16'h5A3C);
        chk("loop cfg", o_p1_output_loop_cfg, 32'h5A3C);
        wr(ad(spd_pkg::IDX_P2_NUM_LOW), 32'h0000_FFFF, 4'h3, r);
        wr(ad(spd_pkg::IDX_P2_NUM_LOW), 32'h0000_0000, 4'h1, r);
        rchk(spd_pkg::IDX_P2_NUM_LOW, 16'hFF00);
    endtask : t_unmapped

    // Main sequence: reset for eight cycles, then the scenarios.
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_ref_div();
        t_int_div();
        t_frac();
        t_dev();
        t_ext();
        t_unmapped();
        close_out();
    end

    // Watchdog; the whole sequence needs well under two thousand cycles.
    initial
    begin
        #(20000 * 5);
        n_fail++;
        close_out();
    end
endmodule : spd_regs_test
